// [lsp_ctrl_regs.sv]
// Purpose: management registers for the low-speed serdes pll, swing and loss-of-signal controls
// Assumes: aresetn synchronous active low; ce low freezes every flop
// Notes:   the second control register is held once per lane
`timescale 1ns/1ps
module lsp_ctrl_regs
    import lsp_pkg::*;
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         ce,
    input  wire logic                         channel_powerdown_n,
    input  wire logic [LSP_ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [LSP_ADDR_W-1:0]        s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic                              ls_pll_on,
    output logic [1:0]                        ls_pll_bw_select,
    output logic [3:0]                        ls_pll_multiplier,
    output logic [LSP_LANES*3-1:0]            ls_output_amplitude,
    output logic [LSP_LANES-1:0]              ls_signal_loss_detect_on
);

    // ==========================================================
    // helpers
    lsp_state_t s_q;
    lsp_state_t s_d;
    logic       wr_go;

    function automatic logic [5:0] reg_idx(input logic [LSP_ADDR_W-1:0] a);
        return a[LSP_ADDR_W-1:2];
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
        return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // lowest lane enabled in the mask is the one read back; empty mask reads lane 0
    function automatic int read_lane(input logic [LSP_LANES-1:0] m);
        int k;
        k = 0;
        for (int i = LSP_LANES - 1; i >= 0; i--) begin
            if (m[i]) begin
                k = i;
            end
        end
        return k;
    endfunction

    assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;

    // ==========================================================
    // next state
    always_comb begin
        logic [LSP_LANES-1:0] mask;
        logic [5:0]           widx;
        logic [5:0]           ridx;
        s_d  = s_q;
        mask = s_q.ctl_one[LSP_MASK_LSB +: LSP_LANES];
        widx = reg_idx(s_q.aw_addr);
        ridx = reg_idx(s_axi_araddr);

        // address and data are taken independently, in either order
        if (s_axi_awvalid && s_q.aw_rdy) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.w_rdy) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata[15:0];
            s_d.w_strb = s_axi_wstrb[1:0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (wr_go) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = LSP_RESP_OKAY;
            case (widx)
                LSP_CTL_ONE_IDX: begin
                    s_d.ctl_one = merge(s_q.ctl_one, s_q.w_data, s_q.w_strb);
                end
                LSP_CTL_TWO_IDX: begin
                    for (int l = 0; l < LSP_LANES; l++) begin
                        if (mask[l]) begin
                            s_d.ctl_two[l] = merge(s_q.ctl_two[l], s_q.w_data, s_q.w_strb);
                        end
                    end
                end
                LSP_PWR_IDX: begin
                    s_d.pwr = merge(s_q.pwr, s_q.w_data, s_q.w_strb);
                end
                LSP_STAT_IDX: begin
                    s_d.bresp = LSP_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = LSP_RESP_SLV;
                end
            endcase
        end
        s_d.aw_rdy = !s_d.aw_full;
        s_d.w_rdy  = !s_d.w_full;

        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.ar_rdy) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = LSP_RESP_OKAY;
            s_d.rdata  = '0;
            case (ridx)
                LSP_CTL_ONE_IDX: begin
                    s_d.rdata[15:0] = s_q.ctl_one;
                end
                LSP_CTL_TWO_IDX: begin
                    s_d.rdata[15:0] = s_q.ctl_two[read_lane(mask)];
                end
                LSP_PWR_IDX: begin
                    s_d.rdata[15:0] = s_q.pwr;
                end
                LSP_STAT_IDX: begin
                    s_d.rdata[1:0] = {channel_powerdown_n, s_q.pll_on};
                end
                default: begin
                    s_d.rresp = LSP_RESP_SLV;
                end
            endcase
        end
        s_d.ar_rdy = !s_d.rvalid;

        s_d.pll_on = s_q.ctl_one[LSP_PLL_EN_BIT] && channel_powerdown_n && !s_q.pwr[LSP_GPD_BIT];
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= LSP_STATE_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all slices of the state flops
    assign s_axi_awready     = s_q.aw_rdy;
    assign s_axi_wready      = s_q.w_rdy;
    assign s_axi_bvalid      = s_q.bvalid;
    assign s_axi_bresp       = s_q.bresp;
    assign s_axi_arready     = s_q.ar_rdy;
    assign s_axi_rvalid      = s_q.rvalid;
    assign s_axi_rresp       = s_q.rresp;
    assign s_axi_rdata       = s_q.rdata;
    assign ls_pll_on         = s_q.pll_on;
    assign ls_pll_bw_select  = s_q.ctl_one[LSP_BW_LSB +: 2];
    assign ls_pll_multiplier = s_q.ctl_one[LSP_MPY_LSB +: 4];

    for (genvar g = 0; g < LSP_LANES; g++) begin : g_lane
        // swing and loss detect per lane
        assign ls_output_amplitude[g*3 +: 3]  = s_q.ctl_two[g][LSP_AMP_LSB +: 3];
        assign ls_signal_loss_detect_on[g]    = s_q.ctl_two[g][LSP_LOS_BIT];
    end

    // ==========================================================
    // checks
    sequence seq_write_cmd(logic [5:0] idx);
        ce && wr_go && reg_idx(s_q.aw_addr) == idx;
    endsequence

    sequence seq_reset_release;
        aresetn && !$past(aresetn);
    endsequence

    chk_pll_forced_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && (!channel_powerdown_n || s_q.pwr[LSP_GPD_BIT]) |=> !ls_pll_on)
        else $error("pll on while powered down");

    chk_pll_enable_on: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && channel_powerdown_n && !s_q.pwr[LSP_GPD_BIT] && s_q.ctl_one[LSP_PLL_EN_BIT] |=> ls_pll_on)
        else $error("pll stays off while enabled");

    chk_ctl_one_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_reset_release |-> ls_pll_bw_select == 2'h1 && ls_pll_multiplier == 4'h5 && ls_pll_on)
        else $error("control one reset value wrong");

    chk_ctl_two_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_reset_release |-> s_q.ctl_two[0] == 16'hdc04 && ls_output_amplitude[2:0] == 3'h5
            && ls_signal_loss_detect_on[0])
        else $error("control two reset value wrong");

    chk_mpy_write: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_write_cmd(LSP_CTL_ONE_IDX) ##0 s_q.w_strb[0] |=> ls_pll_multiplier == $past(s_q.w_data[3:0]))
        else $error("multiplier not written");

    chk_bw_write: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_write_cmd(LSP_CTL_ONE_IDX) ##0 s_q.w_strb[1] |=> ls_pll_bw_select == $past(s_q.w_data[9:8]))
        else $error("bandwidth not written");

    chk_masked_lane: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_write_cmd(LSP_CTL_TWO_IDX) ##0 !s_q.ctl_one[LSP_MASK_LSB] |=> $stable(s_q.ctl_two[0]))
        else $error("masked lane was written");

    chk_swing_los: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_write_cmd(LSP_CTL_TWO_IDX) ##0 s_q.ctl_one[LSP_MASK_LSB] && s_q.w_strb[1]
            |=> ls_output_amplitude[2:0] == $past(s_q.w_data[14:12])
            && ls_signal_loss_detect_on[0] == $past(s_q.w_data[11]))
        else $error("swing or loss detect not written");

    // commit frees both channels in the same edge that raises the answer
    chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wr_go |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write answer missing");

endmodule // lsp_ctrl_regs

// [lsp_pkg.sv]
// Purpose: constants and state type for the low-speed serdes pll control registers
// Assumes: axi4-lite, 32-bit data, 16-bit registers in the low half of each word
// Notes:   byte address of a register is four times its index
package lsp_pkg;

    // ==========================================================
    // bus and lanes
    localparam int          LSP_ADDR_W    = 8;
    localparam int          LSP_LANES     = 4;
    localparam logic [1:0]  LSP_RESP_OKAY = 2'h0;
    localparam logic [1:0]  LSP_RESP_SLV  = 2'h2;

    // ==========================================================
    // register indices
    localparam logic [5:0]  LSP_PWR_IDX     = 6'h01;
    localparam logic [5:0]  LSP_STAT_IDX    = 6'h02;
    localparam logic [5:0]  LSP_CTL_ONE_IDX = 6'h06;
    localparam logic [5:0]  LSP_CTL_TWO_IDX = 6'h07;

    // ==========================================================
    // reset values
    localparam logic [15:0] LSP_CTL_ONE_RST = 16'hf115;
    localparam logic [15:0] LSP_CTL_TWO_RST = 16'hdc04;
    localparam logic [15:0] LSP_PWR_RST     = 16'h0000;

    // ==========================================================
    // field positions
    localparam int LSP_MASK_LSB   = 12;
    localparam int LSP_BW_LSB     = 8;
    localparam int LSP_PLL_EN_BIT = 4;
    localparam int LSP_MPY_LSB    = 0;
    localparam int LSP_AMP_LSB    = 12;
    localparam int LSP_LOS_BIT    = 11;
    localparam int LSP_GPD_BIT    = 15;

    typedef struct packed {
        logic                        aw_rdy;
        logic                        aw_full;
        logic [LSP_ADDR_W-1:0]       aw_addr;
        logic                        w_rdy;
        logic                        w_full;
        logic [15:0]                 w_data;
        logic [1:0]                  w_strb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        ar_rdy;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic [15:0]                 ctl_one;
        logic [15:0]                 pwr;
        logic [LSP_LANES-1:0][15:0]  ctl_two;
        logic                        pll_on;
    } lsp_state_t;

    localparam lsp_state_t LSP_STATE_RST = '{
        aw_rdy  : 1'b1,
        w_rdy   : 1'b1,
        ar_rdy  : 1'b1,
        ctl_one : LSP_CTL_ONE_RST,
        pwr     : LSP_PWR_RST,
        ctl_two : {LSP_LANES{LSP_CTL_TWO_RST}},
        pll_on  : 1'b1,
        default : '0
    };

endpackage

// [lsp_ctrl_regs_tb.sv]
// Purpose: self-checking bench for the low-speed serdes pll control registers
// Assumes: axi4-lite master lives here; prot tied
// Notes:   byte address is four times the register index
`timescale 1ns/1ps
module lsp_ctrl_regs_tb
    import lsp_pkg::*;
;
    localparam logic [7:0] A_PWR  = {LSP_PWR_IDX, 2'b00};
    localparam logic [7:0] A_STAT = {LSP_STAT_IDX, 2'b00};
    localparam logic [7:0] A_ONE  = {LSP_CTL_ONE_IDX, 2'b00};
    localparam logic [7:0] A_TWO  = {LSP_CTL_TWO_IDX, 2'b00};
    logic        aclk = 1'b0;
    logic        aresetn, ce, cpd_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, pll_on;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, mpy, los;
    logic [1:0]  bresp, rresp, bw;
    logic [11:0] amp;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;

    lsp_ctrl_regs lsp_ctrl_regs_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .channel_powerdown_n(cpd_n),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ls_pll_on(pll_on),
        .ls_pll_bw_select(bw), .ls_pll_multiplier(mpy), .ls_output_amplitude(amp),
        .ls_signal_loss_detect_on(los));

    always #2 aclk = ~aclk;

    // ==========================================================
    // verdict and watchdog
    task automatic conclude;
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // whole run needs well under 2000 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            conclude;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // ==========================================================
    // bus cycles: start one edge after the previous ended
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        #1;
    endtask

    task automatic wrc(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", LSP_RESP_OKAY, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk("rresp", LSP_RESP_OKAY, r);
        chk(nm, {16'h0000, e}, d);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk("bw", 2'b01, bw);
        chk("pll_on", 1'b1, pll_on);
        chk("mpy", 4'b0101, mpy);
        chk("amp", 12'hb6d, amp);
        chk("los", 4'hf, los);
        rdc(A_TWO, 16'hdc04, "ctl_two");
        rdc(A_ONE, 16'hf115, "ctl_one");
    endtask

    // reserved codes are stored too, so every code is walked
    task automatic t_codes;
        for (int i = 0; i < 16; i++) begin
            wrc(A_ONE, {4'hf, 2'b00, i[1:0], 4'b0001, i[3:0]});
            chk("bw", i[1:0], bw);
            chk("mpy", i[3:0], mpy);
            rdc(A_ONE, {4'hf, 2'b00, i[1:0], 4'b0001, i[3:0]}, "ctl_one");
        end
        wrc(A_ONE, 16'hf115);
    endtask

    task automatic t_enable;
        wrc(A_ONE, 16'hf105);
        chk("pll_on", 1'b0, pll_on);
        wrc(A_ONE, 16'hf115);
        chk("pll_on", 1'b1, pll_on);
    endtask

    task automatic t_forced;
        @(posedge aclk);
        cpd_n <= 1'b0;
        @(posedge aclk);
        #1;
        chk("pll_on", 1'b0, pll_on);
        @(posedge aclk);
        cpd_n <= 1'b1;
        @(posedge aclk);
        #1;
        chk("pll_on", 1'b1, pll_on);
        wrc(A_PWR, 16'h8000);
        chk("pll_on", 1'b0, pll_on);
        rdc(A_STAT, 16'h0002, "status");
        wrc(A_PWR, 16'h0000);
        chk("pll_on", 1'b1, pll_on);
    endtask

    task automatic t_lanes;
        wrc(A_ONE, 16'h3115);
        wrc(A_TWO, 16'h2000);
        chk("amp", 12'hb52, amp);
        chk("los", 4'hc, los);
        rdc(A_TWO, 16'h2000, "ctl_two");
        wrc(A_ONE, 16'hc115);
        rdc(A_TWO, 16'hdc04, "ctl_two");
        wrc(A_ONE, 16'hf115);
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        wr(8'hfc, 16'hffff, r);
        chk("bresp", LSP_RESP_SLV, r);
        rd(8'hfc, d, r);
        chk("rresp", LSP_RESP_SLV, r);
        chk("amp", 12'hb52, amp);
    endtask

    // a low enable must hold the pll state even while power-down is pulled
    task automatic t_freeze;
        @(posedge aclk);
        ce    <= 1'b0;
        cpd_n <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk("pll_on", 1'b1, pll_on);
        @(posedge aclk);
        ce <= 1'b1;
        @(posedge aclk);
        #1;
        chk("pll_on", 1'b0, pll_on);
        @(posedge aclk);
        cpd_n <= 1'b1;
        @(posedge aclk);
        #1;
        chk("pll_on", 1'b1, pll_on);
    endtask

    // byte strobes: each byte lane of control one written alone
    task automatic t_strobe;
        @(posedge aclk);
        wstrb <= 4'h1;
        wrc(A_ONE, 16'h0000);
        chk("mpy", 4'b0000, mpy);
        chk("bw", 2'b01, bw);
        chk("pll_on", 1'b0, pll_on);
        rdc(A_ONE, 16'hf100, "ctl_one");
        @(posedge aclk);
        wstrb <= 4'h2;
        wrc(A_ONE, 16'hf215);
        chk("bw", 2'b10, bw);
        chk("mpy", 4'b0000, mpy);
        @(posedge aclk);
        wstrb <= 4'hf;
        wrc(A_ONE, 16'hf115);
        chk("pll_on", 1'b1, pll_on);
    endtask

    initial begin
        aresetn = 1'b0;
        ce      = 1'b1;
        cpd_n   = 1'b1;
        awaddr  = 8'h00;
        araddr  = 8'h00;
        wdata   = 32'h0000_0000;
        wstrb   = 4'hf;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        t_reset;
        t_codes;
        t_enable;
        t_forced;
        t_lanes;
        t_unmapped;
        t_freeze;
        t_strobe;
        conclude;
    end
endmodule // lsp_ctrl_regs_tb
